// ===== logic/afm_pkg.sv
package afm_pkg;

    // Setting codes of the opcode-class filter.
    typedef enum logic [1:0] {
        OPC_ANY     = 2'h0,
        OPC_FORWARD = 2'h1,
        OPC_REVERSE = 2'h2,
        OPC_UNKNOWN = 2'h3
    } afm_opclass_t;

    // Setting codes of the request/reply filter.
    typedef enum logic [1:0] {
        RR_ANY     = 2'h0,
        RR_REQUEST = 2'h1,
        RR_REPLY   = 2'h2
    } afm_reqrep_t;

    // Setting codes of the protocol-address filters.
    typedef enum logic [1:0] {
        PA_ANY     = 2'h0,
        PA_HOST    = 2'h1,
        PA_NETWORK = 2'h2
    } afm_pafilt_t;

    // Setting codes of the three-way flag checks.
    typedef enum logic [1:0] {
        TRI_ZERO = 2'h0,
        TRI_ONE  = 2'h1,
        TRI_ANY  = 2'h2
    } afm_tri_t;

    // Frame type selection of an entry.
    typedef enum logic [1:0] {
        FT_ANY     = 2'h0,
        FT_ETHTYPE = 2'h1,
        FT_ARP     = 2'h2,
        FT_IP      = 2'h3
    } afm_ftype_t;

    // Resolution operation codes.
    localparam logic [15:0] OP_FWD_REQUEST = 16'h0001;
    localparam logic [15:0] OP_FWD_REPLY   = 16'h0002;
    localparam logic [15:0] OP_REV_REQUEST = 16'h0003;
    localparam logic [15:0] OP_REV_REPLY   = 16'h0004;

    // Required field constants.
    localparam logic [7:0]  HW_LEN_ETH     = 8'h06;
    localparam logic [7:0]  PROTO_LEN_IP4  = 8'h04;
    localparam logic [15:0] HW_SPACE_ETH   = 16'h0001;
    localparam logic [15:0] PROTO_SPACE_IP = 16'h0800;

    localparam int          CNT_W          = 32;
    localparam logic [31:0] CNT_ONE        = 32'h0000_0001;
    localparam logic [31:0] CNT_ZERO       = 32'h0000_0000;

    // Header fields of one address-resolution frame.
    typedef struct packed {
        logic [47:0] frameSourceMac;
        logic [15:0] hwAddressSpace;
        logic [15:0] protocolAddressSpace;
        logic [7:0]  hwAddressLength;
        logic [7:0]  protocolAddressLength;
        logic [15:0] resolutionOperationCode;
        logic [47:0] senderHwAddress;
        logic [31:0] senderProtocolAddress;
        logic [47:0] targetHwAddress;
        logic [31:0] targetProtocolAddress;
    } afm_frame_t;

    // Configuration of one access control entry.
    typedef struct packed {
        afm_ftype_t  frameType;
        logic        denyAction;
        afm_opclass_t opClass;
        afm_reqrep_t reqRep;
        afm_pafilt_t senderFilt;
        logic [31:0] senderAddr;
        logic [31:0] senderMask;
        afm_pafilt_t targetFilt;
        logic [31:0] targetAddr;
        logic [31:0] targetMask;
        afm_tri_t    senderMacChk;
        afm_tri_t    targetMacChk;
        afm_tri_t    lengthChk;
        afm_tri_t    hwSpaceChk;
        afm_tri_t    protoSpaceChk;
    } afm_entry_t;

endpackage : afm_pkg

// ===== logic/afm_hit_counter.sv
`timescale 1ns/100ps
// Hit counter of one entry; cleared by clear pulse, a hit in the same cycle is counted after the clear.
module afm_hit_counter (
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    input  wire logic                     hit,
    input  wire logic                     clear,
    output logic [afm_pkg::CNT_W-1:0]     count
);

    logic [afm_pkg::CNT_W-1:0] count_q;
    logic [afm_pkg::CNT_W-1:0] count_d;

    // A hit in the clear cycle restarts the count at one.
    assign count_d = hit ? ((clear ? afm_pkg::CNT_ZERO : count_q)
                            + afm_pkg::CNT_ONE)
                   : (clear ? afm_pkg::CNT_ZERO : count_q);
    assign count   = count_q;

    // Counter register.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= afm_pkg::CNT_ZERO;
        end else begin
            count_q <= count_d;
        end
    end

endmodule : afm_hit_counter

// ===== logic/afm_arp_filter.sv
`timescale 1ns/100ps
module afm_arp_filter (
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    input  wire logic                      frameValid,
    input  wire logic                      frameIsArp,
    input  wire afm_pkg::afm_frame_t       frame,
    input  wire afm_pkg::afm_entry_t       accessControlEntry,
    input  wire logic                      counterClear,
    output logic                           resultValid,
    output logic                           entryHit,
    output logic                           frameDrop,
    output logic                           framePermit,
    output logic [afm_pkg::CNT_W-1:0]      hitCount
);

    // Opcode decoding.
    wire logic opFwd;
    wire logic opRev;
    wire logic opReq;
    wire logic opRep;
    assign opFwd = (frame.resolutionOperationCode == afm_pkg::OP_FWD_REQUEST)
                || (frame.resolutionOperationCode == afm_pkg::OP_FWD_REPLY);
    assign opRev = (frame.resolutionOperationCode == afm_pkg::OP_REV_REQUEST)
                || (frame.resolutionOperationCode == afm_pkg::OP_REV_REPLY);
    assign opReq = (frame.resolutionOperationCode == afm_pkg::OP_FWD_REQUEST)
                || (frame.resolutionOperationCode == afm_pkg::OP_REV_REQUEST);
    assign opRep = (frame.resolutionOperationCode == afm_pkg::OP_FWD_REPLY)
                || (frame.resolutionOperationCode == afm_pkg::OP_REV_REPLY);

    // Opcode class filter.
    wire logic opClassOk;
    assign opClassOk =
        (accessControlEntry.opClass == afm_pkg::OPC_ANY)
     || ((accessControlEntry.opClass == afm_pkg::OPC_FORWARD) && opFwd)
     || ((accessControlEntry.opClass == afm_pkg::OPC_REVERSE) && opRev)
     || ((accessControlEntry.opClass == afm_pkg::OPC_UNKNOWN)
         && !opFwd && !opRev);

    // Request or reply filter; an undefined code matches nothing.
    wire logic reqRepOk;
    assign reqRepOk =
        (accessControlEntry.reqRep == afm_pkg::RR_ANY)
     || ((accessControlEntry.reqRep == afm_pkg::RR_REQUEST) && opReq)
     || ((accessControlEntry.reqRep == afm_pkg::RR_REPLY) && opRep);

    // Protocol address filters.
    wire logic senderOk;
    wire logic targetOk;
    assign senderOk =
        (accessControlEntry.senderFilt == afm_pkg::PA_ANY)
     || ((accessControlEntry.senderFilt == afm_pkg::PA_HOST)
         && (frame.senderProtocolAddress
             == accessControlEntry.senderAddr))
     || ((accessControlEntry.senderFilt == afm_pkg::PA_NETWORK)
         && ((frame.senderProtocolAddress & accessControlEntry.senderMask)
             == (accessControlEntry.senderAddr
                 & accessControlEntry.senderMask)));
    assign targetOk =
        (accessControlEntry.targetFilt == afm_pkg::PA_ANY)
     || ((accessControlEntry.targetFilt == afm_pkg::PA_HOST)
         && (frame.targetProtocolAddress
             == accessControlEntry.targetAddr))
     || ((accessControlEntry.targetFilt == afm_pkg::PA_NETWORK)
         && ((frame.targetProtocolAddress & accessControlEntry.targetMask)
             == (accessControlEntry.targetAddr
                 & accessControlEntry.targetMask)));

    // Flag conditions for the three-way checks.
    wire logic senderMacEq;
    wire logic targetMacEq;
    wire logic lengthEq;
    wire logic hwSpaceEq;
    wire logic protoSpaceEq;
    assign senderMacEq  = frame.senderHwAddress == frame.frameSourceMac;
    assign targetMacEq  = frame.targetHwAddress == frame.frameSourceMac;
    assign lengthEq     = (frame.hwAddressLength == afm_pkg::HW_LEN_ETH)
                       && (frame.protocolAddressLength
                           == afm_pkg::PROTO_LEN_IP4);
    assign hwSpaceEq    = frame.hwAddressSpace == afm_pkg::HW_SPACE_ETH;
    assign protoSpaceEq = frame.protocolAddressSpace
                       == afm_pkg::PROTO_SPACE_IP;

    // Three-way check: one needs the condition, zero its complement.
    function automatic logic triCheck(input afm_pkg::afm_tri_t sel,
                                      input logic cond);
        triCheck = (sel == afm_pkg::TRI_ANY)
                || ((sel == afm_pkg::TRI_ONE) && cond)
                || ((sel == afm_pkg::TRI_ZERO) && !cond);
    endfunction : triCheck

    wire logic senderMacOk;
    wire logic targetMacOk;
    wire logic lengthOk;
    wire logic hwSpaceOk;
    wire logic protoSpaceOk;
    assign senderMacOk  = triCheck(accessControlEntry.senderMacChk,
                                   senderMacEq);
    // Target MAC check applies to reverse frames only; others pass it.
    assign targetMacOk  = !opRev
                       || triCheck(accessControlEntry.targetMacChk,
                                   targetMacEq);
    assign lengthOk     = triCheck(accessControlEntry.lengthChk,
                                   lengthEq);
    assign hwSpaceOk    = triCheck(accessControlEntry.hwSpaceChk,
                                   hwSpaceEq);
    assign protoSpaceOk = triCheck(accessControlEntry.protoSpaceChk,
                                   protoSpaceEq);

    // Overall match of the entry.
    wire logic arpSelected;
    wire logic fieldsOk;
    wire logic matchNow;
    assign arpSelected = accessControlEntry.frameType == afm_pkg::FT_ARP;
    assign fieldsOk = opClassOk && reqRepOk && senderOk && targetOk
                   && senderMacOk && targetMacOk && lengthOk
                   && hwSpaceOk && protoSpaceOk;
    // Other frame types are not this block's concern; only ARP frames hit.
    assign matchNow = frameValid && frameIsArp && arpSelected
                   && fieldsOk;

    // Registered decision, one cycle after the frame is offered.
    logic valid_q;
    logic hit_q;
    logic drop_q;
    logic permit_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            valid_q  <= 1'b0;
            hit_q    <= 1'b0;
            drop_q   <= 1'b0;
            permit_q <= 1'b0;
        end else begin
            valid_q  <= frameValid;
            hit_q    <= matchNow;
            drop_q   <= matchNow && accessControlEntry.denyAction;
            permit_q <= matchNow && !accessControlEntry.denyAction;
        end
    end

    assign resultValid = valid_q;
    assign entryHit    = hit_q;
    assign frameDrop   = drop_q;
    assign framePermit = permit_q;

    // Hit counter of the entry.
    afm_hit_counter afm_hit_counter_i (
        .clk   (clk),
        .rst_b (rst_b),
        .hit   (matchNow),
        .clear (counterClear),
        .count (hitCount)
    );

    // Assertions.
    logic [afm_pkg::CNT_W-1:0] cntPast;
    assign cntPast = hitCount;

    sequence s_offerMatch;
        frameValid && frameIsArp && arpSelected && fieldsOk;
    endsequence

    property p_notArp;
        @(posedge clk) disable iff (!rst_b)
        (frameValid && !arpSelected) |=> !entryHit;
    endproperty
    a_notArp: assert property (p_notArp)
        else $error("hit on an entry not selecting ARP");

    property p_opForward;
        @(posedge clk) disable iff (!rst_b)
        (accessControlEntry.opClass == afm_pkg::OPC_FORWARD && !opFwd
         && frameValid) |=> !entryHit;
    endproperty
    a_opForward: assert property (p_opForward)
        else $error("forward class hit by other opcode");

    property p_reqRep;
        @(posedge clk) disable iff (!rst_b)
        (accessControlEntry.reqRep == afm_pkg::RR_REPLY && opReq)
        |=> !entryHit;
    endproperty
    a_reqRep: assert property (p_reqRep)
        else $error("reply setting hit by request opcode");

    property p_senderHost;
        @(posedge clk) disable iff (!rst_b)
        (accessControlEntry.senderFilt == afm_pkg::PA_HOST
         && frame.senderProtocolAddress != accessControlEntry.senderAddr)
        |=> !entryHit;
    endproperty
    a_senderHost: assert property (p_senderHost)
        else $error("sender host filter hit on other address");

    property p_length;
        @(posedge clk) disable iff (!rst_b)
        (accessControlEntry.lengthChk == afm_pkg::TRI_ONE
         && frame.hwAddressLength != afm_pkg::HW_LEN_ETH) |=> !entryHit;
    endproperty
    a_length: assert property (p_length)
        else $error("length check hit on wrong length");

    property p_protoSpace;
        @(posedge clk) disable iff (!rst_b)
        (accessControlEntry.protoSpaceChk == afm_pkg::TRI_ZERO
         && protoSpaceEq) |=> !entryHit;
    endproperty
    a_protoSpace: assert property (p_protoSpace)
        else $error("zero setting hit on matching space");

    property p_action;
        @(posedge clk) disable iff (!rst_b)
        s_offerMatch |=> (frameDrop == $past(accessControlEntry.denyAction))
                         && (framePermit != frameDrop);
    endproperty
    a_action: assert property (p_action)
        else $error("action does not follow the entry");

    property p_count;
        @(posedge clk) disable iff (!rst_b)
        (s_offerMatch and !counterClear) |=>
            hitCount == $past(cntPast) + afm_pkg::CNT_ONE;
    endproperty
    a_count: assert property (p_count)
        else $error("hit counter did not step");

    property p_senderMac;
        @(posedge clk) disable iff (!rst_b)
        (accessControlEntry.senderMacChk == afm_pkg::TRI_ONE
         && !senderMacEq) |=> !entryHit;
    endproperty
    a_senderMac: assert property (p_senderMac)
        else $error("sender MAC check hit on mismatch");

    property p_opReverse;
        @(posedge clk) disable iff (!rst_b)
        (accessControlEntry.opClass == afm_pkg::OPC_REVERSE && !opRev
         && frameValid) |=> !entryHit;
    endproperty
    a_opReverse: assert property (p_opReverse)
        else $error("reverse class hit by other opcode");

    property p_opUnknown;
        @(posedge clk) disable iff (!rst_b)
        (accessControlEntry.opClass == afm_pkg::OPC_UNKNOWN
         && (opFwd || opRev)) |=> !entryHit;
    endproperty
    a_opUnknown: assert property (p_opUnknown)
        else $error("unknown class hit by a known opcode");

    property p_request;
        @(posedge clk) disable iff (!rst_b)
        (accessControlEntry.reqRep == afm_pkg::RR_REQUEST && !opReq)
        |=> !entryHit;
    endproperty
    a_request: assert property (p_request)
        else $error("request setting hit by other opcode");

    property p_targetHost;
        @(posedge clk) disable iff (!rst_b)
        (accessControlEntry.targetFilt == afm_pkg::PA_HOST
         && frame.targetProtocolAddress != accessControlEntry.targetAddr)
        |=> !entryHit;
    endproperty
    a_targetHost: assert property (p_targetHost)
        else $error("target host filter hit on other address");

    property p_targetMac;
        @(posedge clk) disable iff (!rst_b)
        (frameValid && opRev && !targetMacEq
         && accessControlEntry.targetMacChk == afm_pkg::TRI_ONE)
        |=> !entryHit;
    endproperty
    a_targetMac: assert property (p_targetMac)
        else $error("target MAC check hit on mismatch");

    property p_hwSpace;
        @(posedge clk) disable iff (!rst_b)
        (accessControlEntry.hwSpaceChk == afm_pkg::TRI_ONE
         && !hwSpaceEq) |=> !entryHit;
    endproperty
    a_hwSpace: assert property (p_hwSpace)
        else $error("hardware space check hit on wrong space");

    property p_protoSpaceOne;
        @(posedge clk) disable iff (!rst_b)
        (accessControlEntry.protoSpaceChk == afm_pkg::TRI_ONE
         && !protoSpaceEq) |=> !entryHit;
    endproperty
    a_protoSpaceOne: assert property (p_protoSpaceOne)
        else $error("protocol space check hit on wrong space");

    property p_clear;
        @(posedge clk) disable iff (!rst_b)
        (counterClear && !matchNow) |=> hitCount == afm_pkg::CNT_ZERO;
    endproperty
    a_clear: assert property (p_clear)
        else $error("hit counter not cleared");

endmodule : afm_arp_filter

// ===== dv/afm_arp_filter_test.sv
`timescale 1ns/100ps
module afm_arp_filter_test;

    logic                         clk;
    logic                         rst_b;
    logic                         frameValid;
    logic                         frameIsArp;
    logic                         counterClear;
    logic                         resultValid;
    logic                         entryHit;
    logic                         frameDrop;
    logic                         framePermit;
    logic [afm_pkg::CNT_W-1:0]    hitCount;
    logic [31:0]                  expCount;
    afm_pkg::afm_frame_t          frame;
    afm_pkg::afm_frame_t          base;
    afm_pkg::afm_entry_t          ent;
    afm_pkg::afm_entry_t          baseEnt;
    int                           n_fail = 0;
    int                           checked = 0;
    int                           cycles = 0;

    afm_arp_filter afm_arp_filter_i (
        .clk(clk), .rst_b(rst_b), .frameValid(frameValid),
        .frameIsArp(frameIsArp), .frame(frame), .accessControlEntry(ent),
        .counterClear(counterClear), .resultValid(resultValid),
        .entryHit(entryHit), .frameDrop(frameDrop),
        .framePermit(framePermit), .hitCount(hitCount)
    );

    // The clock toggles every half period of 10 ns.
    initial clk = 1'b0;
    always #10 clk = ~clk;

    // A hung run is cut short well after all scenarios should be done.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            end_of_test;
        end
    end

    task automatic end_of_test;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    // Compares one value and reports a difference at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic chk1(input logic seen, input logic exp);
        check({31'h0, seen}, {31'h0, exp});
    endtask : chk1

    // Three-way flag setting: zero wants false, one wants true, any passes.
    function automatic logic tri3(input logic [1:0] s, input logic c);
        case (s)
            2'h0: return !c;
            2'h1: return c;
            2'h2: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : tri3

    function automatic logic pa(input logic [1:0] s, input logic [31:0] a,
                                input logic [31:0] c, input logic [31:0] m);
        case (s)
            2'h0: return 1'b1;
            2'h1: return a == c;
            2'h2: return (a & m) == (c & m);
            default: return 1'b0;
        endcase
    endfunction : pa

    // Reference match of a frame against the present entry.
    function automatic logic model(input afm_pkg::afm_frame_t f,
                                   input logic arp);
        logic [15:0] op;
        logic        fw;
        logic        rv;
        logic        ok;
        op = f.resolutionOperationCode;
        fw = (op == 16'h0001) || (op == 16'h0002);
        rv = (op == 16'h0003) || (op == 16'h0004);
        ok = arp && (ent.frameType == afm_pkg::FT_ARP);
        case (ent.opClass)
            afm_pkg::OPC_FORWARD: ok &= fw;
            afm_pkg::OPC_REVERSE: ok &= rv;
            afm_pkg::OPC_UNKNOWN: ok &= !(fw || rv);
            default: ;
        endcase
        case (ent.reqRep)
            afm_pkg::RR_ANY: ;
            afm_pkg::RR_REQUEST: ok &= (op == 16'h0001) || (op == 16'h0003);
            afm_pkg::RR_REPLY: ok &= (op == 16'h0002) || (op == 16'h0004);
            default: ok = 1'b0;
        endcase
        ok &= pa(ent.senderFilt, f.senderProtocolAddress, ent.senderAddr,
                 ent.senderMask);
        ok &= pa(ent.targetFilt, f.targetProtocolAddress, ent.targetAddr,
                 ent.targetMask);
        ok &= tri3(ent.senderMacChk,
                   f.senderHwAddress == f.frameSourceMac);
        if (rv) ok &= tri3(ent.targetMacChk,
                           f.targetHwAddress == f.frameSourceMac);
        ok &= tri3(ent.lengthChk, f.hwAddressLength == 8'h06 &&
                   f.protocolAddressLength == 8'h04);
        ok &= tri3(ent.hwSpaceChk, f.hwAddressSpace == 16'h0001);
        ok &= tri3(ent.protoSpaceChk,
                   f.protocolAddressSpace == 16'h0800);
        return ok;
    endfunction : model

    // Offers one frame; valid stays high so frames can run back to back.
    task automatic offer(input afm_pkg::afm_frame_t f, input logic arp,
                         output logic s, output logic e);
        e = model(f, arp);
        frame = f;
        frameIsArp = arp;
        frameValid = 1'b1;
        @(posedge clk);
        #1;
        expCount = (counterClear ? 32'h0 : expCount) + {31'h0, e};
        s = entryHit;
        chk1(resultValid, 1'b1);
        chk1(frameDrop, e & ent.denyAction);
        chk1(framePermit, e & !ent.denyAction);
        check(hitCount, expCount);
    endtask : offer

    // One cycle without a frame; every decision output must then be low.
    task automatic idle;
        frameValid = 1'b0;
        @(posedge clk);
        #1;
        chk1(resultValid | entryHit | frameDrop | framePermit, 1'b0);
    endtask : idle

    task automatic t_type;
        logic s, e;
        for (int i = 0; i < 4; i++) begin
            ent.frameType = afm_pkg::afm_ftype_t'(i[1:0]);
            offer(base, 1'b1, s, e);
            chk1(s, i == 2);
        end
        ent = baseEnt;
        offer(base, 1'b0, s, e);
        chk1(s, 1'b0);
        idle;
    endtask : t_type

    // Every opcode class and request/reply setting against opcodes 1 to 5.
    task automatic t_opcode;
        logic s, e;
        afm_pkg::afm_frame_t f;
        f = base;
        for (int a = 0; a < 4; a++) begin
            for (int b = 0; b < 4; b++) begin
                for (int k = 1; k < 6; k++) begin
                    ent.opClass = afm_pkg::afm_opclass_t'(a[1:0]);
                    ent.reqRep = afm_pkg::afm_reqrep_t'(b[1:0]);
                    f.resolutionOperationCode = {13'h0, k[2:0]};
                    offer(f, 1'b1, s, e);
                    chk1(s, e);
                end
            end
        end
        ent = baseEnt;
        idle;
    endtask : t_opcode

    // Host, same network and other network addresses on both sides.
    task automatic t_paddr;
        logic s, e;
        logic [31:0] adr [3] = '{32'hC0A80105, 32'hC0A80163, 32'hC0A90105};
        afm_pkg::afm_frame_t f;
        for (int i = 0; i < 3; i++) begin
            for (int j = 0; j < 3; j++) begin
                ent = baseEnt;
                ent.senderFilt = afm_pkg::afm_pafilt_t'(i[1:0]);
                f = base;
                f.senderProtocolAddress = adr[j];
                offer(f, 1'b1, s, e);
                chk1(s, i == 0 || j == 0 || (i == 2 && j == 1));
                ent = baseEnt;
                ent.targetFilt = afm_pkg::afm_pafilt_t'(i[1:0]);
                f = base;
                f.targetProtocolAddress = adr[j];
                offer(f, 1'b1, s, e);
                chk1(s, i == 0 || j == 0 || (i == 2 && j == 1));
            end
        end
        ent = baseEnt;
        idle;
    endtask : t_paddr

    task automatic t_mac;
        logic s, e;
        afm_pkg::afm_frame_t f;
        for (int t = 0; t < 3; t++) begin
            for (int j = 0; j < 2; j++) begin
                ent.senderMacChk = afm_pkg::afm_tri_t'(t[1:0]);
                ent.targetMacChk = afm_pkg::TRI_ANY;
                f = base;
                if (j == 1) f.senderHwAddress = ~base.frameSourceMac;
                offer(f, 1'b1, s, e);
                chk1(s, t == 2 || t == 1 - j);
                ent.senderMacChk = afm_pkg::TRI_ANY;
                ent.targetMacChk = afm_pkg::afm_tri_t'(t[1:0]);
                f.senderHwAddress = base.senderHwAddress;
                f.targetHwAddress = j[0] ? base.frameSourceMac : 48'h0;
                f.resolutionOperationCode = 16'h0003;
                offer(f, 1'b1, s, e);
                chk1(s, t == 2 || t == j);
                f.resolutionOperationCode = 16'h0001;
                offer(f, 1'b1, s, e);
                chk1(s, 1'b1);
            end
        end
        ent = baseEnt;
        idle;
    endtask : t_mac

    // Each field check in every setting against good and bad field values.
    task automatic t_fields;
        logic s, e;
        afm_pkg::afm_frame_t f;
        afm_pkg::afm_tri_t tv;
        for (int c = 0; c < 3; c++) begin
            for (int t = 0; t < 3; t++) begin
                for (int v = 0; v < 5; v++) begin
                    ent = baseEnt;
                    tv = afm_pkg::afm_tri_t'(t[1:0]);
                    if (c == 0) ent.lengthChk = tv;
                    else if (c == 1) ent.hwSpaceChk = tv;
                    else ent.protoSpaceChk = tv;
                    f = base;
                    if (v == 1) f.hwAddressLength = 8'h07;
                    if (v == 2) f.protocolAddressLength = 8'h05;
                    if (v == 3) f.hwAddressSpace = 16'h0006;
                    if (v == 4) f.protocolAddressSpace = 16'h86DD;
                    offer(f, 1'b1, s, e);
                    chk1(s, e);
                end
            end
        end
        ent = baseEnt;
        idle;
    endtask : t_fields

    // Deny and permit outcomes, then counter clears with and without a hit.
    task automatic t_action;
        logic s, e;
        ent.denyAction = 1'b1;
        offer(base, 1'b1, s, e);
        chk1(s, 1'b1);
        ent.opClass = afm_pkg::OPC_REVERSE;
        offer(base, 1'b1, s, e);
        chk1(s, 1'b0);
        ent = baseEnt;
        counterClear = 1'b1;
        offer(base, 1'b1, s, e);
        counterClear = 1'b0;
        offer(base, 1'b1, s, e);
        idle;
        counterClear = 1'b1;
        @(posedge clk);
        #1;
        counterClear = 1'b0;
        expCount = 32'h0;
        check(hitCount, expCount);
    endtask : t_action

    // Reset, then each scenario in turn.
    initial begin
        rst_b = 1'b0;
        frameValid = 1'b0;
        frameIsArp = 1'b0;
        counterClear = 1'b0;
        expCount = 32'h0;
        base = '{48'h0A0B0C0D0E0F, 16'h0001, 16'h0800, 8'h06, 8'h04,
                 16'h0001, 48'h0A0B0C0D0E0F, 32'hC0A80105, 48'h0,
                 32'hC0A80101};
        baseEnt = '{afm_pkg::FT_ARP, 1'b0, afm_pkg::OPC_ANY, afm_pkg::RR_ANY,
                    afm_pkg::PA_ANY, 32'hC0A80105, 32'hFFFFFF00,
                    afm_pkg::PA_ANY, 32'hC0A80105, 32'hFFFFFF00,
                    afm_pkg::TRI_ANY, afm_pkg::TRI_ANY, afm_pkg::TRI_ANY,
                    afm_pkg::TRI_ANY, afm_pkg::TRI_ANY};
        frame = base;
        ent = baseEnt;
        repeat (5) @(posedge clk);
        #1;
        rst_b = 1'b1;
        check(hitCount, 32'h0);
        chk1(resultValid | entryHit | frameDrop | framePermit, 1'b0);
        t_type;
        t_opcode;
        t_paddr;
        t_mac;
        t_fields;
        t_action;
        end_of_test;
    end

endmodule : afm_arp_filter_test
